// >>> inc/sfq_pkg.sv
package sfq_pkg;
  // clock rate and self-timed status write duration
  localparam int CLK_PERIOD_NS = 4;
  localparam int TW_US         = 10;
  localparam int TW_CYC        = (TW_US * 1000) / CLK_PERIOD_NS;
  localparam logic [15:0] TW_CNT = 16'(TW_CYC - 1);

  // opcodes
  localparam logic [7:0] OP_STATUS_WRITE_CMD  = 8'h01;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD  = 8'h06;
  localparam logic [7:0] OP_FAST  = 8'h0B;
  localparam logic [7:0] OP_DUAL  = 8'h3B;
  localparam logic [7:0] OP_VOLEN = 8'h50;

  // phase lengths in serial clocks
  localparam logic [5:0] OP_BITS   = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] DATA_BITS = 6'h08;
  localparam logic [5:0] CNT_MAX   = 6'h3F;
  localparam logic [5:0] DUMMY_STD = 6'h08;
  localparam logic [5:0] DUMMY_Q2  = 6'h04;
  localparam logic [5:0] DUMMY_Q3  = 6'h06;
  localparam logic [5:0] DUMMY_Q4  = 6'h08;
  localparam logic [5:0] DUMMY_Q5  = 6'h0A;

  // dummy-byte setting codes
  localparam logic [1:0] DC_3B   = 2'h0;
  localparam logic [1:0] DC_2B   = 2'h1;
  localparam logic [1:0] DC_4B   = 2'h2;
  localparam logic [1:0] DC_5B   = 2'h3;
  localparam logic [1:0] DC_RST  = DC_3B;

  // output shifter
  localparam logic [3:0] REM_SINGLE = 4'h7;
  localparam logic [3:0] REM_DUAL   = 4'h6;
  localparam logic [3:0] STEP_SINGLE = 4'h1;
  localparam logic [3:0] STEP_DUAL   = 4'h2;

  // fields of the status write data byte
  localparam int SRP_POS = 7;
  localparam int BP_LSB  = 2;
  localparam int OTP_LSB = 3;

  typedef enum logic [5:0] {
    ST_CMD   = 6'b000001,
    ST_ADDR  = 6'b000010,
    ST_DUMMY = 6'b000100,
    ST_DATA  = 6'b001000,
    ST_WDATA = 6'b010000,
    ST_IGN   = 6'b100000
  } sfq_state_t;

  typedef struct packed {
    logic       status_protect_bit;
    logic       rsvd;
    logic [3:0] block_protect;
    logic       write_enable_latch;
    logic       busy_flag;
  } sfq_stat_t;

  typedef struct packed {
    logic otp_lock;
    logic protect_pin_disable;
    logic hold_reset_select;
    logic top_bottom_select;
    logic small_block_select;
  } sfq_otp_t;
endpackage

// >>> core/sfq_flash_seq.sv
`timescale 1ns/1ps
// Notes on behaviour
// - setting picks 2-5 dummy bytes, quad clocks
// - status write needs write-enable latch set
// - status write: exactly eight data bits
// - valid status write starts timed busy cycle
// - status reads served while write busy
// - busy and latch bits untouched by write
// - protect bits written; blocked when hardware protected
// - otp mode bits only set once
// - normal read: opcode, address, no dummies
// - address increments per byte, wraps zero
// - chip select high ends read, releases output
// - reads rejected during busy cycles
// - fast read: one dummy byte after address
// - dual read: eight dummy clocks
// - dual read drives two bits per clock
// - dummy clock inputs ignored
// - dummy count in two volatile bits

module sfq_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8,
  parameter int LW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          flush,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [LW-1:0]      level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic          push;
  logic          pop;

  assign in_ready  = (level != LW'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage has no reset; only pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // pointers and fill level, flush wins over traffic
  always_ff @(posedge clk) begin
    if (!rst_b || flush) begin
      wp_r  <= '0;
      rp_r  <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
      end
      level <= level + LW'(push) - LW'(pop);
    end
  end
endmodule

module sfq_flash_seq #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              io_line_zero_i,
  output logic                   io_line_zero_o,
  output logic                   io_line_zero_oe_n,
  output logic                   io_line_one_o,
  output logic                   io_line_one_oe_n,
  input  wire logic              wp_n,
  input  wire logic              quad_mode,
  input  wire logic              otp_mode,
  input  wire logic              ext_busy,
  input  wire logic              dummy_code_wr,
  input  wire logic [1:0]        dummy_code_in,
  output logic [1:0]             dummy_code,
  output logic [23:0]            mem_addr,
  output logic                   mem_ready,
  input  wire logic              mem_valid,
  input  wire logic [7:0]        mem_data,
  output sfq_pkg::sfq_stat_t     status,
  output sfq_pkg::sfq_otp_t      otp_bits
);
  import sfq_pkg::*;
  localparam int LW = $clog2(FIFO_DEPTH + 1);

  logic [1:0]  sclk_q;
  logic [1:0]  cs_q;
  logic [1:0]  io0_q;
  logic [1:0]  wp_q;
  logic        sclk_d_r;
  logic        cs_d_r;
  logic        rise;
  logic        fall;
  logic        cs_s;
  logic        cs_rise;
  logic        din;
  sfq_state_t  state_r;
  logic [7:0]  op_r;
  logic [7:0]  op_nxt;
  logic [5:0]  cnt_r;
  logic [5:0]  dummy_len_r;
  logic [23:0] addr_sh_r;
  logic [7:0]  wd_sh_r;
  logic        dual_r;
  logic        st_rd_r;
  logic        busy_r;
  logic        wel_r;
  logic        srp_r;
  logic [3:0]  bp_r;
  logic        vol_en_r;
  logic [15:0] tmr_r;
  logic        hardware_protected_mode;
  logic        busy_any;
  logic        status_write_cmd_ok;
  logic        write_enable_cmd_ok;
  logic        volen_ok;
  logic        wr_done;
  logic [7:0]  sh_r;
  logic [3:0]  rem_r;
  logic [7:0]  src;
  logic [7:0]  stat_byte;
  logic        fetch_on_r;
  logic        fifo_pop;
  logic        fifo_push;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_data;
  logic [LW-1:0] fifo_level;

  // dummy clocks for a high-performance read
  function automatic logic [5:0] dummy_clks(input logic [1:0] code,
                                            input logic quad,
                                            input logic dual_op);
    logic [5:0] n;
    n = DUMMY_STD;
    if (quad && !dual_op) begin
      unique case (code)
        DC_2B:   n = DUMMY_Q2;
        DC_3B:   n = DUMMY_Q3;
        DC_4B:   n = DUMMY_Q4;
        DC_5B:   n = DUMMY_Q5;
      endcase
    end
    return n;
  endfunction

  function automatic logic [5:0] sat_inc(input logic [5:0] v);
    return (v == CNT_MAX) ? v : v + 6'h01;
  endfunction

  // two-flop synchronisers for every pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclk_q <= 2'h0;
      cs_q   <= 2'h3;
      io0_q  <= 2'h0;
      wp_q   <= 2'h3;
    end else begin
      sclk_q <= {sclk_q[0], sclk};
      cs_q   <= {cs_q[0], cs_n};
      io0_q  <= {io0_q[0], io_line_zero_i};
      wp_q   <= {wp_q[0], wp_n};
    end
  end

  // edge detection on synchronised levels
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
    end else begin
      sclk_d_r <= sclk_q[1];
      cs_d_r   <= cs_q[1];
    end
  end

  assign cs_s    = cs_q[1];
  assign cs_rise = cs_s & ~cs_d_r;
  assign rise    = sclk_q[1] & ~sclk_d_r & ~cs_s;
  assign fall    = ~sclk_q[1] & sclk_d_r & ~cs_s;
  assign din     = io0_q[1];
  assign op_nxt  = {op_r[6:0], din};
  assign busy_any = busy_r | ext_busy;
  assign hardware_protected_mode     = srp_r & ~wp_q[1];

  // command framing, chip select high restarts everything
  always_ff @(posedge clk) begin
    if (!rst_b || cs_s) begin
      state_r     <= ST_CMD;
      cnt_r       <= '0;
      op_r        <= '0;
      dual_r      <= 1'b0;
      st_rd_r     <= 1'b0;
      dummy_len_r <= DUMMY_STD;
      addr_sh_r   <= '0;
      wd_sh_r     <= '0;
    end else if (rise) begin
      unique case (state_r)
        ST_CMD: begin
          op_r  <= op_nxt;
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == OP_BITS - 6'h01) begin
            cnt_r <= '0;
            dual_r <= (op_nxt == OP_DUAL);
            dummy_len_r <= dummy_clks(dummy_code, quad_mode,
                                      op_nxt == OP_DUAL);
            unique case (op_nxt)
              OP_READ, OP_FAST, OP_DUAL: begin
                // a running write cycle is left alone
                state_r <= busy_any ? ST_IGN : ST_ADDR;
              end
              OP_RDSR: begin
                state_r <= ST_DATA;
                st_rd_r <= 1'b1;
              end
              OP_STATUS_WRITE_CMD: state_r <= ST_WDATA;
              default: state_r <= ST_IGN;
            endcase
          end
        end
        ST_ADDR: begin
          addr_sh_r <= {addr_sh_r[22:0], din};
          cnt_r     <= cnt_r + 6'h01;
          if (cnt_r == ADDR_BITS - 6'h01) begin
            cnt_r   <= '0;
            state_r <= (op_r == OP_READ) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          // input during dummy clocks is not looked at
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == dummy_len_r - 6'h01) begin
            state_r <= ST_DATA;
          end
        end
        ST_WDATA: begin
          wd_sh_r <= {wd_sh_r[6:0], din};
          cnt_r   <= sat_inc(cnt_r);
        end
        ST_IGN: begin
          cnt_r <= sat_inc(cnt_r);
        end
        ST_DATA: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end

  // the latch only counts if exactly eight bits followed the opcode
  assign status_write_cmd_ok  = cs_rise && state_r == ST_WDATA && cnt_r == DATA_BITS
                    && wel_r && !hardware_protected_mode && !busy_any;
  assign write_enable_cmd_ok  = cs_rise && state_r == ST_IGN && cnt_r == '0
                    && op_r == OP_WRITE_ENABLE_CMD;
  assign volen_ok = cs_rise && state_r == ST_IGN && cnt_r == '0
                    && op_r == OP_VOLEN;
  assign wr_done  = busy_r && tmr_r == '0;

  // self-timed write cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
      tmr_r  <= '0;
    end else if (status_write_cmd_ok) begin
      busy_r <= 1'b1;
      tmr_r  <= TW_CNT;
    end else if (wr_done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      tmr_r <= tmr_r - 16'h0001;
    end
  end

  // write-enable latch, a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wel_r <= 1'b0;
    end else begin
      wel_r <= write_enable_cmd_ok | (wel_r & ~wr_done);
    end
  end

  // protect and otp fields; low two status bits are never written
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      srp_r    <= 1'b0;
      bp_r     <= '0;
      otp_bits <= '0;
      vol_en_r <= 1'b0;
    end else begin
      if (volen_ok) begin
        vol_en_r <= 1'b1;
      end
      if (status_write_cmd_ok) begin
        vol_en_r <= 1'b0;
        if (otp_mode && !vol_en_r) begin
          // bits can only go to one, so each sets once
          otp_bits <= otp_bits | wd_sh_r[OTP_LSB +: 5];
        end else begin
          srp_r <= wd_sh_r[SRP_POS];
          bp_r  <= wd_sh_r[BP_LSB +: 4];
        end
      end
    end
  end

  // dummy-byte setting, volatile, defaults to three bytes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dummy_code <= DC_RST;
    end else if (dummy_code_wr) begin
      dummy_code <= dummy_code_in;
    end
  end

  assign stat_byte = {srp_r, 1'b0, bp_r, wel_r, busy_r};

  // registered copy of the live status
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status <= '0;
    end else begin
      status <= stat_byte;
    end
  end

  // prefetch address runs ahead of the shifter
  always_ff @(posedge clk) begin
    if (!rst_b || cs_s) begin
      fetch_on_r <= 1'b0;
      mem_ready  <= 1'b0;
      mem_addr   <= '0;
    end else begin
      if (rise && state_r == ST_ADDR && cnt_r == ADDR_BITS - 6'h01) begin
        mem_addr   <= {addr_sh_r[22:0], din};
        fetch_on_r <= 1'b1;
      end else if (fifo_push) begin
        mem_addr <= mem_addr + 24'h000001;
      end
      // one spare slot covers the push already in flight
      mem_ready <= fetch_on_r &&
                   fifo_level <= LW'(FIFO_DEPTH - 2);
    end
  end

  assign fifo_push = mem_valid & mem_ready;
  assign fifo_pop  = fall && state_r == ST_DATA && !st_rd_r
                     && rem_r == '0;
  assign src       = st_rd_r ? stat_byte : fifo_data;

  sfq_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .flush     (cs_s),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (mem_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );

  // output shifter on falling serial clock edges
  always_ff @(posedge clk) begin
    if (!rst_b || cs_s) begin
      io_line_zero_o    <= 1'b0;
      io_line_zero_oe_n <= 1'b1;
      io_line_one_o     <= 1'b0;
      io_line_one_oe_n  <= 1'b1;
      sh_r              <= '0;
      rem_r             <= '0;
    end else if (fall && state_r == ST_DATA) begin
      io_line_one_oe_n  <= 1'b0;
      io_line_zero_oe_n <= ~dual_r;
      if (rem_r == '0) begin
        io_line_one_o  <= src[7];
        io_line_zero_o <= src[6];
        sh_r  <= dual_r ? src << STEP_DUAL : src << STEP_SINGLE;
        rem_r <= dual_r ? REM_DUAL : REM_SINGLE;
      end else begin
        io_line_one_o  <= sh_r[7];
        io_line_zero_o <= sh_r[6];
        sh_r  <= dual_r ? sh_r << STEP_DUAL : sh_r << STEP_SINGLE;
        rem_r <= rem_r - (dual_r ? STEP_DUAL : STEP_SINGLE);
      end
    end
  end
endmodule

// >>> testbench/sfq_host.sv
`timescale 1ns/1ps
// host side of the serial link: mode 0, sclk idle low, 48 ns period
module sfq_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic dq0,
  input  wire logic dq1
);
  // idle frame levels
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // odd offset keeps link edges off the core clock grid
  task automatic sel();
    #1.3 cs_n = 1'b0;
    #24;
  endtask

  // shift n bits, launched before each rise
  task automatic put(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      mosi = v[i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  endtask

  // input released: toggling so a stale level never passes for data
  task automatic get(output logic [7:0] b, input logic dual);
    for (int i = 7; i >= 0; i -= (dual ? 2 : 1)) begin
      mosi = ~mosi;
      #24 sclk = 1'b1;
      b[i] = dq1;
      if (dual) begin
        b[i-1] = dq0;
      end
      #24 sclk = 1'b0;
    end
  endtask

  // end of frame, then the minimum high time
  task automatic desel();
    #24 cs_n = 1'b1;
    #40;
  endtask
endmodule

// >>> testbench/sfq_flash_seq_chk.sv
`timescale 1ns/1ps
module sfq_chk (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               cs_n,
  input wire logic               io_line_zero_oe_n,
  input wire logic               io_line_one_oe_n,
  input wire logic               wp_n,
  input wire logic               ext_busy,
  input wire logic               dummy_code_wr,
  input wire logic [1:0]         dummy_code_in,
  input wire logic [1:0]         dummy_code,
  input wire logic [23:0]        mem_addr,
  input wire logic               mem_ready,
  input wire logic               mem_valid,
  input wire sfq_pkg::sfq_stat_t status,
  input wire sfq_pkg::sfq_otp_t  otp_bits
);
  import sfq_pkg::*;
  int unsigned busy_cnt_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // length of the running busy stretch; one cycle of slack for the edge detect
  always_ff @(posedge clk) begin
    if (!rst_b || !status.busy_flag) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= busy_cnt_r + 1;
    end
  end

  rel_oe_a: assert property (cs_n [*8] |-> io_line_one_oe_n && io_line_zero_oe_n)
    else $error("output enable still low after deselect");
  dual_oe_a: assert property (!io_line_zero_oe_n |-> !io_line_one_oe_n)
    else $error("second line driven without the first");
  wr_gate_a: assert property ($rose(status.busy_flag) |->
    $past(status.write_enable_latch) && status.write_enable_latch)
    else $error("status write ran without the latch");
  busy_len_a: assert property ($fell(status.busy_flag) |->
    busy_cnt_r >= TW_CYC - 1 && busy_cnt_r <= TW_CYC + 1)
    else $error("busy stretch has the wrong length");
  wel_clr_a: assert property ($fell(status.busy_flag) |-> !status.write_enable_latch)
    else $error("latch not cleared at write end");
  hpm_keep_a: assert property ((status.status_protect_bit && !wp_n) [*8] |=>
    $stable(status.block_protect))
    else $error("protect bits changed while protected");
  otp_once_a: assert property ((otp_bits & $past(otp_bits)) == $past(otp_bits))
    else $error("one-time bit went back to zero");
  // a deselect in the accept cycle clears the address and the request together
  addr_inc_a: assert property (mem_valid && mem_ready |=>
    mem_addr == $past(mem_addr) + 24'h1 || (mem_addr == '0 && !mem_ready))
    else $error("read address did not step");
  rd_rej_a: assert property ($rose(mem_ready) |->
    !status.busy_flag && !$past(ext_busy))
    else $error("read started during a busy cycle");
  code_ld_a: assert property (dummy_code_wr |=> dummy_code == $past(dummy_code_in))
    else $error("dummy code not loaded");

  // main scenarios reached
  cover property (!io_line_zero_oe_n);
  cover property ($fell(status.busy_flag));
  cover property ($fell(mem_ready) && !cs_n);
endmodule

bind sfq_flash_seq sfq_chk u_chk (.*);

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import sfq_pkg::*;
  logic        clk, rst_b, sclk, cs_n, io_line_zero_i, dq1;
  logic        io_line_zero_o, io_line_zero_oe_n, io_line_one_o, io_line_one_oe_n;
  logic        wp_n, quad_mode, otp_mode, ext_busy, dummy_code_wr, mem_ready, mem_valid;
  logic        mosi;
  logic [1:0]  dummy_code_in, dummy_code;
  logic [23:0] mem_addr;
  logic [7:0]  mem_data, rb;
  logic [7:0]  tbl [3];
  logic [4:0]  otp_exp;
  sfq_stat_t   status;
  sfq_otp_t    otp_bits;
  int          n_fail, checks_done;

  sfq_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .dq0(io_line_zero_i), .dq1(dq1));
  sfq_flash_seq #(.FIFO_DEPTH(8)) DUT (.*);

  // wire levels; a released line shows a changing pattern, not its last value
  assign io_line_zero_i = io_line_zero_oe_n ? mosi : io_line_zero_o;
  assign dq1            = io_line_one_oe_n ? ~mosi : io_line_one_o;
  assign mem_data       = mem_addr[7:0] ^ mem_addr[23:16];

  // memory stalls every other cycle, yet still outpaces the link, so the buffer fills and throttles the source
  always @(posedge clk) begin
    mem_valid <= !mem_valid;
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [7:0] eb(input logic [23:0] a);
    return a[7:0] ^ a[23:16];
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmd(input logic [31:0] v, input int n);
    host.sel();
    host.put(v, n);
    host.desel();
  endtask

  // nb of zero means the read is expected to be refused
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nd,
                    input int nb, input logic dual);
    logic [7:0] v;
    host.sel();
    host.put({24'h0, op}, 8);
    host.put({8'h0, a}, 24);
    host.put(32'hAAAAAAAA, nd);
    for (int k = 0; k < nb; k++) begin
      host.get(v, dual);
      chk(v, eb(a + 24'(k)));
    end
    if (nb == 0) begin
      #30;
      chk({io_line_one_oe_n, mem_ready}, 2'b10);
    end
    host.desel();
    chk({io_line_one_oe_n, io_line_zero_oe_n}, 2'b11);
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 4000 && status.busy_flag !== 1'b0; i++) begin
      @(posedge clk);
    end
    if (i == 4000) begin
      n_fail++;
      summarize();
    end
  endtask

  initial begin
    rst_b = 1'b0;
    wp_n = 1'b1;
    {quad_mode, otp_mode, ext_busy, dummy_code_wr, mem_valid} = 5'h00;
    dummy_code_in = 2'h0;
    n_fail = 0;
    checks_done = 0;
    tbl = '{8'h28, 8'h00, 8'h50};
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk(status, 8'h00);
    chk(dummy_code, DC_RST);
    rd(OP_READ, 24'hFFFFFE, 0, 3, 1'b0);
    rd(OP_FAST, 24'h123456, 8, 2, 1'b0);
    rd(OP_DUAL, 24'h00FF10, 8, 2, 1'b1);
    // quad dummy lengths per code; code 00 for odd start, 01 for aligned
    @(posedge clk) quad_mode <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk) dummy_code_in <= 2'(c);
      dummy_code_wr <= 1'b1;
      @(posedge clk) dummy_code_wr <= 1'b0;
      @(posedge clk);
      chk(dummy_code, c);
      rd(OP_FAST, (c == 1) ? 24'h000104 : 24'h000105, (c == 0) ? 6 : (c == 1) ? 4 : 2 * c + 4,
         1, 1'b0);
    end
    @(posedge clk) quad_mode <= 1'b0;
    // status write gating, framing, busy cycle
    cmd({16'h0, OP_STATUS_WRITE_CMD, 8'h3C}, 16);
    repeat (8) @(posedge clk);
    chk(status, 8'h00);
    cmd({24'h0, OP_WRITE_ENABLE_CMD}, 8);
    chk(status, 8'h02);
    cmd({15'h0, OP_STATUS_WRITE_CMD, 8'h3C, 1'b1}, 17);
    repeat (8) @(posedge clk);
    chk(status, 8'h02);
    cmd({16'h0, OP_STATUS_WRITE_CMD, 8'hBF}, 16);
    chk(status[1:0], 2'b11);
    host.sel();
    host.put({24'h0, OP_RDSR}, 8);
    host.get(rb, 1'b0);
    host.desel();
    chk(rb[1:0], 2'b11);
    rd(OP_READ, 24'h000020, 8, 0, 1'b0);
    wait_idle();
    chk(status, 8'hBC);
    // hardware protection blocks the write
    @(posedge clk) wp_n <= 1'b0;
    cmd({24'h0, OP_WRITE_ENABLE_CMD}, 8);
    cmd({16'h0, OP_STATUS_WRITE_CMD, 8'h00}, 16);
    repeat (8) @(posedge clk);
    chk(status, 8'hBE);
    @(posedge clk) wp_n <= 1'b1;
    cmd({16'h0, OP_STATUS_WRITE_CMD, 8'h00}, 16);
    wait_idle();
    chk(status, 8'h00);
    @(posedge clk) ext_busy <= 1'b1;
    rd(OP_FAST, 24'h000010, 8, 0, 1'b0);
    @(posedge clk) ext_busy <= 1'b0;
    // one-time bits only accumulate
    @(posedge clk) otp_mode <= 1'b1;
    otp_exp = 5'h00;
    for (int k = 0; k < 3; k++) begin
      cmd({24'h0, OP_WRITE_ENABLE_CMD}, 8);
      cmd({16'h0, OP_STATUS_WRITE_CMD, tbl[k]}, 16);
      wait_idle();
      otp_exp = otp_exp | tbl[k][7:3];
      chk(otp_bits, otp_exp);
    end
    // volatile enable lets the next write reach the protect bits instead
    cmd({24'h0, OP_VOLEN}, 8);
    cmd({24'h0, OP_WRITE_ENABLE_CMD}, 8);
    cmd({16'h0, OP_STATUS_WRITE_CMD, 8'h04}, 16);
    wait_idle();
    chk(status, 8'h04);
    chk(otp_bits, otp_exp);
    summarize();
  end
endmodule
